// >>> rtl/mip_pkg.sv
// Package for the maskable interrupt priority block
// Assumes an APB master on the same clock as the block
package mip_pkg;
  localparam int NSRC = 15;
  localparam int SEL_W = 4;
  localparam int IDX_W = 4;
  // Source indices, highest fixed priority first
  localparam logic [3:0] SRC_EXT    = 4'h0;
  localparam logic [3:0] SRC_TICK   = 4'h1;
  localparam logic [3:0] SRC_CAP1   = 4'h2;
  localparam logic [3:0] SRC_CAP2   = 4'h3;
  localparam logic [3:0] SRC_CAP3   = 4'h4;
  localparam logic [3:0] SRC_CMP1   = 4'h5;
  localparam logic [3:0] SRC_CMP4   = 4'h8;
  localparam logic [3:0] SRC_SHARED = 4'h9;
  localparam logic [3:0] SRC_TWRAP  = 4'ha;
  localparam logic [3:0] SRC_AWRAP  = 4'hb;
  localparam logic [3:0] SRC_AEDGE  = 4'hc;
  localparam logic [3:0] SRC_SYNC   = 4'hd;
  localparam logic [3:0] SRC_ASYNC  = 4'he;
  localparam logic [3:0] NO_SRC     = 4'hf;
  // Register byte offsets
  localparam logic [7:0] OFS_FLAG   = 8'h00;
  localparam logic [7:0] OFS_MASK   = 8'h04;
  localparam logic [7:0] OFS_PROMO  = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_TICK   = 8'h14;
  localparam logic [7:0] OFS_CMP1   = 8'h18;
  localparam logic [7:0] OFS_CMP2   = 8'h1c;
  localparam logic [7:0] OFS_CMP3   = 8'h20;
  localparam logic [7:0] OFS_CMP4   = 8'h24;
  localparam logic [7:0] OFS_CMP5   = 8'h28;
  localparam logic [7:0] OFS_CNT    = 8'h2c;
  // Control register bits
  localparam int CTL_GDIS    = 0;
  localparam int CTL_SHMODE  = 1;
  localparam int CTL_CAPEDGE = 2;
  localparam int CTL_ACCEN   = 3;
  localparam logic [3:0] PROMO_RST = 4'h0;
  localparam logic [15:0] TICK_RST = 16'h0fff;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [7:0]  ACC_MAX  = 8'hff;
  localparam logic [3:0]  SYNC_EVT_W = 4'h3;
  localparam logic [3:0]  ASYNC_EVT_W = 4'h4;
endpackage : mip_pkg

// >>> rtl/mip_top.sv
// Maskable interrupt priority resolver with local timer sources
// Assumes APB master on CLK; pins asynchronous; serial units give one-cycle pulses
//
// Behaviour
// - Pending requests are served by fixed rank, not arrival order.
// - Exactly one source may be promoted above all others by software.
// - A non-maskable request outranks every maskable request, served at once.
// - Fifteen sources ranked ext pin, tick, captures, compares, shared, wraps, accumulator edge, serial.
// - External request recognised while its active-low pin is low.
// - Tick source requests at a programmable regular period.
// - Captures 1, 2, 3 request on chosen edge at port A pins 2, 1, 0.
// - Compares 1 to 4 request when free count equals their value.
// - Shared channel requests on pin 3 edge or compare match by mode.
// - Timer wrap requests when 16-bit count goes from max to zero.
// - Accumulator wrap requests when 8-bit count goes from max to zero.
// - Accumulator edge requests after an edge on port A pin 7.
// - Sync serial done, collision, or mode fault share one request.
// - Async serial four events merge into one request, cause readable.
// - Serve only when global disable clear and request is highest.
// - Promoted source chosen by a four-bit selection field.
// - After reset the external pin is highest maskable source.
// - Each source has a local enable bit, enabled when one.
// - Flags set on events regardless of mask.
// - Setting mask with flag already set recognises at once.
// - Recognised only while flag and mask both set.
// - Writing one clears a flag; zero leaves it; software cannot set.
// - Entering service sets global disable; return restores the saved bit.
`timescale 1ns/1ps
module mip_top #(
  parameter int CNT_W = 16,
  parameter int ACC_W = 8
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic [31:0] PADDR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXT_REQ_N,
  input  wire logic        NMI_REQ_N,
  input  wire logic [7:0]  PORTA_IN,
  input  wire logic [2:0]  SYNC_EVT,
  input  wire logic [3:0]  ASYNC_EVT,
  input  wire logic        SVC_ENTER,
  input  wire logic        SVC_RETURN,
  output logic             IRQ_REQ,
  output logic [3:0]       IRQ_ID,
  output logic             NMI_REQ,
  output logic             GLOBAL_DIS
);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(mip_pkg::CNT_MAX);
  localparam logic [ACC_W-1:0] ACC_TOP = ACC_W'(mip_pkg::ACC_MAX);

  typedef enum logic [1:0] {
    MIP_IDLE  = 2'b00,
    MIP_SETUP = 2'b01,
    MIP_RESP  = 2'b10
  } mip_bus_t;

  // Two-flop synchronisers; first stage read only by the second
  logic [9:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      // Port A pins idle low, request pins idle high: no false edge after reset
      sync1_q <= 10'h300;
      sync2_q <= 10'h300;
      prev_q  <= 10'h300;
    end else begin
      sync1_q <= {NMI_REQ_N, EXT_REQ_N, PORTA_IN};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  wire logic [7:0] pa_now  = sync2_q[7:0];
  wire logic [7:0] pa_prev = prev_q[7:0];

  // Software registers
  logic [14:0]      flag_q, mask_q, flag_d;
  logic [3:0]       promo_q;
  logic [3:0]       ctrl_q;
  logic [15:0]      tick_per_q;
  logic [CNT_W-1:0] cmp_q [5];
  logic [CNT_W-1:0] cnt_q;
  logic [ACC_W-1:0] acc_q;
  logic [15:0]      tick_q;
  logic [3:0]       async_cause_q;
  logic [2:0]       sync_cause_q;
  logic             gdis_q, gdis_saved_q;
  mip_bus_t         bus_q;
  logic [31:0]      prdata_q;
  logic             pready_q, pslverr_q;

  function automatic logic edge_hit(input logic now, input logic prv, input logic rising);
    edge_hit = rising ? (now & ~prv) : (~now & prv);
  endfunction

  // Write lands only on the edge where the master samples ready high
  wire logic wr_acc = PSEL & PENABLE & PWRITE & (bus_q == MIP_RESP);
  wire logic [7:0] wa = PADDR[7:0];

  // Free-running timer and periodic tick divider
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cnt_q  <= '0;
      tick_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      tick_q <= (tick_q >= tick_per_q) ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  // Pulse accumulator counts pin 7 edges when enabled
  wire logic pa7_edge = edge_hit(pa_now[7], pa_prev[7], ctrl_q[mip_pkg::CTL_CAPEDGE]);
  always_ff @(posedge CLK) begin
    if (!RSTN) acc_q <= '0;
    else if (ctrl_q[mip_pkg::CTL_ACCEN] && pa7_edge) acc_q <= acc_q + ACC_W'(1);
  end

  // Event vector, index = fixed rank
  logic [14:0] evt;
  always_comb begin
    evt = '0;
    evt[mip_pkg::SRC_EXT]  = ~sync2_q[8];
    evt[mip_pkg::SRC_TICK] = (tick_q == tick_per_q);
    for (int i = 0; i < 3; i++) begin
      evt[mip_pkg::SRC_CAP1 + i] = edge_hit(pa_now[2-i], pa_prev[2-i], ctrl_q[mip_pkg::CTL_CAPEDGE]);
    end
    for (int i = 0; i < 4; i++) begin
      evt[mip_pkg::SRC_CMP1 + i] = (cnt_q == cmp_q[i]);
    end
    evt[mip_pkg::SRC_SHARED] = ctrl_q[mip_pkg::CTL_SHMODE]
      ? edge_hit(pa_now[3], pa_prev[3], ctrl_q[mip_pkg::CTL_CAPEDGE]) : (cnt_q == cmp_q[4]);
    evt[mip_pkg::SRC_TWRAP] = (cnt_q == CNT_TOP);
    evt[mip_pkg::SRC_AWRAP] = ctrl_q[mip_pkg::CTL_ACCEN] && pa7_edge && (acc_q == ACC_TOP);
    evt[mip_pkg::SRC_AEDGE] = pa7_edge;
    evt[mip_pkg::SRC_SYNC]  = |SYNC_EVT;
    evt[mip_pkg::SRC_ASYNC] = |ASYNC_EVT;
  end

  // Flags: set wins over write-one clear
  always_comb begin
    flag_d = flag_q;
    if (wr_acc && wa == mip_pkg::OFS_FLAG) flag_d = flag_d & ~PWDATA[14:0];
    flag_d = flag_d | evt;
  end
  always_ff @(posedge CLK) begin
    if (!RSTN) flag_q <= '0;
    else flag_q <= flag_d;
  end

  // Cause bits for serial units, cleared by write one
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sync_cause_q  <= '0;
      async_cause_q <= '0;
    end else begin
      async_cause_q <= ((wr_acc && wa == mip_pkg::OFS_STAT) ? async_cause_q & ~PWDATA[3:0] : async_cause_q)
                       | ASYNC_EVT;
      sync_cause_q  <= ((wr_acc && wa == mip_pkg::OFS_STAT) ? sync_cause_q & ~PWDATA[6:4] : sync_cause_q)
                       | SYNC_EVT;
    end
  end

  // Writable configuration
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      mask_q     <= '0;
      promo_q    <= mip_pkg::PROMO_RST;
      ctrl_q     <= '0;
      tick_per_q <= mip_pkg::TICK_RST;
      for (int i = 0; i < 5; i++) cmp_q[i] <= '0;
    end else if (wr_acc) begin
      if (wa == mip_pkg::OFS_MASK)  mask_q <= PWDATA[14:0];
      if (wa == mip_pkg::OFS_PROMO) promo_q <= PWDATA[3:0];
      if (wa == mip_pkg::OFS_CTRL)  ctrl_q <= {PWDATA[3:1], 1'b0};
      if (wa == mip_pkg::OFS_TICK)  tick_per_q <= PWDATA[15:0];
      for (int i = 0; i < 5; i++) begin
        if (wa == mip_pkg::OFS_CMP1 + 8'(4 * i)) cmp_q[i] <= PWDATA[CNT_W-1:0];
      end
    end
  end

  // Global disable with save/restore
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      gdis_q       <= 1'b1;
      gdis_saved_q <= 1'b1;
    end else if (SVC_ENTER) begin
      gdis_saved_q <= gdis_q;
      gdis_q       <= 1'b1;
    end else if (SVC_RETURN) begin
      gdis_q <= gdis_saved_q;
    end else if (wr_acc && wa == mip_pkg::OFS_CTRL) begin
      gdis_q <= PWDATA[mip_pkg::CTL_GDIS];
    end
  end

  // Priority resolve
  logic [14:0] recog;
  logic [3:0]  win;
  always_comb begin
    recog = flag_q & mask_q;
    win = mip_pkg::NO_SRC;
    for (int i = mip_pkg::NSRC - 1; i >= 0; i--) begin
      if (recog[i]) win = 4'(i);
    end
    if (promo_q < mip_pkg::NO_SRC && recog[promo_q]) win = promo_q;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      IRQ_REQ <= 1'b0;
      IRQ_ID  <= mip_pkg::NO_SRC;
      NMI_REQ <= 1'b0;
      GLOBAL_DIS <= 1'b1;
    end else begin
      NMI_REQ <= ~sync2_q[9];
      IRQ_REQ <= (win != mip_pkg::NO_SRC) && !gdis_q && sync2_q[9];
      IRQ_ID  <= win;
      GLOBAL_DIS <= gdis_q;
    end
  end

  // APB slave, one wait state
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      bus_q     <= MIP_IDLE;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      case (bus_q)
        MIP_IDLE: begin
          if (PSEL && !PENABLE) bus_q <= MIP_SETUP;
        end
        MIP_SETUP: begin
          bus_q    <= MIP_RESP;
          pready_q <= 1'b1;
          pslverr_q <= (wa > mip_pkg::OFS_CNT) || (wa[1:0] != 2'b00) || (PADDR[31:8] != 24'h000000);
          case (wa)
            mip_pkg::OFS_FLAG:  prdata_q <= {17'h0, flag_q};
            mip_pkg::OFS_MASK:  prdata_q <= {17'h0, mask_q};
            mip_pkg::OFS_PROMO: prdata_q <= {28'h0, promo_q};
            mip_pkg::OFS_CTRL:  prdata_q <= {28'h0, ctrl_q[3:1], gdis_q};
            mip_pkg::OFS_STAT:  prdata_q <= {20'h0, win, 1'b0, sync_cause_q, async_cause_q};
            mip_pkg::OFS_TICK:  prdata_q <= {16'h0, tick_per_q};
            mip_pkg::OFS_CNT:   prdata_q <= {16'h0, 16'(cnt_q)};
            default: begin
              prdata_q <= '0;
              for (int i = 0; i < 5; i++) begin
                if (wa == mip_pkg::OFS_CMP1 + 8'(4 * i)) prdata_q <= {16'h0, 16'(cmp_q[i])};
              end
            end
          endcase
        end
        MIP_RESP: bus_q <= MIP_IDLE;
        default:  bus_q <= MIP_IDLE;
      endcase
    end
  end
  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;

  // Checks
  // clear by one
  a_flag_clear: assert property (@(posedge CLK) disable iff (!RSTN)
    wr_acc && wa == mip_pkg::OFS_FLAG && PWDATA[0] && !evt[0] |=> !flag_q[0])
    else $error("flag not cleared");
  a_flag_set: assert property (@(posedge CLK) disable iff (!RSTN)
    evt[1] |=> flag_q[1])
    else $error("flag not set");
  a_gdis_gate: assert property (@(posedge CLK) disable iff (!RSTN)
    gdis_q |=> !IRQ_REQ)
    else $error("request while disabled");
  a_mask_gate: assert property (@(posedge CLK) disable iff (!RSTN)
    win != mip_pkg::NO_SRC |-> mask_q[win] && flag_q[win])
    else $error("unrecognised winner");
  a_fixed_rank: assert property (@(posedge CLK) disable iff (!RSTN)
    !recog[0] && !recog[1] && recog[2] && recog[3] && promo_q != 4'h3 |-> win == 4'h2)
    else $error("rank wrong");
  a_promo_win: assert property (@(posedge CLK) disable iff (!RSTN)
    promo_q < mip_pkg::NO_SRC && recog[promo_q] |-> win == promo_q)
    else $error("promotion ignored");
  a_nmi_first: assert property (@(posedge CLK) disable iff (!RSTN)
    NMI_REQ |-> !IRQ_REQ)
    else $error("maskable beside nmi");
  a_svc_enter: assert property (@(posedge CLK) disable iff (!RSTN)
    SVC_ENTER ##1 !SVC_ENTER && !SVC_RETURN && !wr_acc |-> ##1 GLOBAL_DIS)
    else $error("disable not set on entry");
  a_svc_return: assert property (@(posedge CLK) disable iff (!RSTN)
    SVC_RETURN && !SVC_ENTER |=> gdis_q == $past(gdis_saved_q))
    else $error("disable not restored");
  a_timer_wrap: assert property (@(posedge CLK) disable iff (!RSTN)
    cnt_q == CNT_TOP |=> cnt_q == '0 && flag_q[mip_pkg::SRC_TWRAP])
    else $error("wrap flag missing");
  a_ext_level: assert property (@(posedge CLK) disable iff (!RSTN)
    !sync2_q[8] |=> flag_q[mip_pkg::SRC_EXT])
    else $error("external request lost");
  a_tick_period: assert property (@(posedge CLK) disable iff (!RSTN)
    evt[mip_pkg::SRC_TICK] |=> tick_q == '0 && flag_q[mip_pkg::SRC_TICK])
    else $error("tick period wrong");
  a_cmp_match: assert property (@(posedge CLK) disable iff (!RSTN)
    cnt_q == cmp_q[0] |=> flag_q[mip_pkg::SRC_CMP1])
    else $error("compare flag missing");
  a_accum_wrap: assert property (@(posedge CLK) disable iff (!RSTN)
    evt[mip_pkg::SRC_AWRAP] |=> acc_q == '0 && flag_q[mip_pkg::SRC_AWRAP])
    else $error("accumulator wrap missing");
  a_accum_edge: assert property (@(posedge CLK) disable iff (!RSTN)
    pa7_edge |=> flag_q[mip_pkg::SRC_AEDGE])
    else $error("accumulator edge missing");
  a_sync_merge: assert property (@(posedge CLK) disable iff (!RSTN)
    SYNC_EVT != 3'h0 |=> flag_q[mip_pkg::SRC_SYNC])
    else $error("sync request missing");
  a_async_cause: assert property (@(posedge CLK) disable iff (!RSTN)
    ASYNC_EVT != 4'h0 |=> flag_q[mip_pkg::SRC_ASYNC] && (async_cause_q & $past(ASYNC_EVT)) == $past(ASYNC_EVT))
    else $error("async cause lost");
  a_reset_promo: assert property (@(posedge CLK)
    !RSTN |=> promo_q == mip_pkg::PROMO_RST && !IRQ_REQ && GLOBAL_DIS)
    else $error("reset state wrong");
  c_promoted: cover property (@(posedge CLK) promo_q != 4'h0 && win == promo_q);
  c_serve: cover property (@(posedge CLK) IRQ_REQ ##1 SVC_ENTER);
  c_nmi: cover property (@(posedge CLK) NMI_REQ);
  c_async_served: cover property (@(posedge CLK) IRQ_REQ && IRQ_ID == mip_pkg::SRC_ASYNC);
  c_accum_wrap: cover property (@(posedge CLK) evt[mip_pkg::SRC_AWRAP]);
endmodule // mip_top

// >>> sim/mip_partner.sv
// Peripheral pins and core service strobes facing the priority block
// Assumes its tasks are called just after a rising CLK edge
`timescale 1ns/1ps
module mip_partner (
  input  wire logic       CLK,
  output logic            EXT_REQ_N,
  output logic            NMI_REQ_N,
  output logic [7:0]      PORTA_IN,
  output logic [2:0]      SYNC_EVT,
  output logic [3:0]      ASYNC_EVT,
  output logic            SVC_ENTER,
  output logic            SVC_RETURN
);
  initial begin
    EXT_REQ_N = 1'b1;
    NMI_REQ_N = 1'b1;
    PORTA_IN  = 8'h00;
    {SVC_RETURN, SVC_ENTER, ASYNC_EVT, SYNC_EVT} = 9'h000;
  end
  task automatic lvl(input logic e, input logic n);
    EXT_REQ_N <= e;
    NMI_REQ_N <= n;
    repeat (4) @(posedge CLK);
  endtask
  // Held long enough for the pin synchroniser
  task automatic pa(input int b);
    PORTA_IN[b] <= 1'b1;
    repeat (4) @(posedge CLK);
    PORTA_IN[b] <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  task automatic pulse(input logic [8:0] v);
    {SVC_RETURN, SVC_ENTER, ASYNC_EVT, SYNC_EVT} <= v;
    @(posedge CLK);
    {SVC_RETURN, SVC_ENTER, ASYNC_EVT, SYNC_EVT} <= 9'h000;
    @(posedge CLK);
  endtask
endmodule // mip_partner

// >>> sim/tb_maskable_interrupt_priority.sv
// Bench for the maskable interrupt priority block
// Assumes mip_top and mip_partner on one CLK; APB mastered here
`timescale 1ns/1ps
module tb_maskable_interrupt_priority;
  logic        CLK     = 1'b0;
  logic        RSTN    = 1'b0;
  logic [31:0] PADDR   = 32'h0;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [31:0] PWDATA  = 32'h0;
  logic [31:0] PRDATA, rv;
  logic [7:0]  PORTA_IN;
  logic [2:0]  SYNC_EVT;
  logic [3:0]  ASYNC_EVT, IRQ_ID;
  logic        PREADY, PSLVERR, EXT_REQ_N, NMI_REQ_N, SVC_ENTER, SVC_RETURN;
  logic        IRQ_REQ, NMI_REQ, GLOBAL_DIS, re;
  int          n_errors = 0;
  int          compares = 0;
  always #2.5 CLK = ~CLK;
  mip_top uut (.CLK(CLK), .RSTN(RSTN), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_REQ_N(EXT_REQ_N),
    .NMI_REQ_N(NMI_REQ_N), .PORTA_IN(PORTA_IN), .SYNC_EVT(SYNC_EVT), .ASYNC_EVT(ASYNC_EVT),
    .SVC_ENTER(SVC_ENTER), .SVC_RETURN(SVC_RETURN), .IRQ_REQ(IRQ_REQ), .IRQ_ID(IRQ_ID),
    .NMI_REQ(NMI_REQ), .GLOBAL_DIS(GLOBAL_DIS));
  mip_partner peer (.CLK(CLK), .EXT_REQ_N(EXT_REQ_N), .NMI_REQ_N(NMI_REQ_N), .PORTA_IN(PORTA_IN),
    .SYNC_EVT(SYNC_EVT), .ASYNC_EVT(ASYNC_EVT), .SVC_ENTER(SVC_ENTER), .SVC_RETURN(SVC_RETURN));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // Request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PADDR  <= {24'h0, a};
    PWRITE <= w;
    PWDATA <= d;
    PSEL   <= 1'b1;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rv = PRDATA;
    re = PSLVERR;
    if (n >= 20) chk(32'h0, 32'h1, "no ready");
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k, input string m);
    apb(1'b0, a, 32'h0);
    chk(rv & k, e, m);
  endtask
  // Outputs as {NMI_REQ, GLOBAL_DIS, IRQ_REQ, IRQ_ID}
  task automatic wout(input logic [6:0] e, input string m);
    int n;
    n = 0;
    while ({NMI_REQ, GLOBAL_DIS, IRQ_REQ, IRQ_ID} !== e && n < 40) begin
      @(posedge CLK);
      n++;
    end
    chk({NMI_REQ, GLOBAL_DIS, IRQ_REQ, IRQ_ID}, e, m);
  endtask
  initial begin
    int e;
    repeat (20) @(posedge CLK);
    RSTN <= 1'b1;
    wout(7'h2f, "reset outputs");
    rdc(mip_pkg::OFS_PROMO, 32'h0, 32'hffffffff, "promo reset");
    rdc(mip_pkg::OFS_MASK, 32'h0, 32'hffffffff, "mask reset");
    $display("test reset done");
    wr(mip_pkg::OFS_CTRL, 32'hf);
    wr(mip_pkg::OFS_FLAG, 32'h7fff);
    for (int i = 0; i < 4; i++) begin
      wr(mip_pkg::OFS_FLAG, 32'h4000);
      peer.pulse(9'h8 << i);
      rdc(mip_pkg::OFS_FLAG, 32'h4000, 32'h4000, "async flag");
      rdc(mip_pkg::OFS_STAT, 32'h1 << i, 32'h1 << i, "async cause");
    end
    for (int i = 0; i < 3; i++) begin
      wr(mip_pkg::OFS_FLAG, 32'h2000);
      peer.pulse(9'h1 << i);
      rdc(mip_pkg::OFS_FLAG, 32'h2000, 32'h2000, "sync flag");
      rdc(mip_pkg::OFS_STAT, 32'h10 << i, 32'h10 << i, "sync cause");
    end
    for (int b = 0; b < 4; b++) peer.pa(b);
    rdc(mip_pkg::OFS_FLAG, 32'h21c, 32'h21c, "capture flags");
    // Shared channel to compare mode, global disable kept set
    wr(mip_pkg::OFS_CTRL, 32'hd);
    wr(mip_pkg::OFS_FLAG, 32'h200);
    for (int k = 0; k < 256; k++) peer.pa(7);
    wr(mip_pkg::OFS_TICK, 32'h20);
    apb(1'b0, mip_pkg::OFS_CNT, 32'h0);
    e = rv + 300;
    for (int k = 0; k < 5; k++) wr(mip_pkg::OFS_CMP1 + 8'(4 * k), e);
    e = 0;
    do begin
      apb(1'b0, mip_pkg::OFS_FLAG, 32'h0);
      e++;
    end while (rv[10] !== 1'b1 && e < 20000);
    peer.lvl(1'b0, 1'b1);
    rdc(mip_pkg::OFS_FLAG, 32'h7fff, 32'h7fff, "all flags");
    wout(7'h2f, "masked sources");
    $display("test events done");
    wr(mip_pkg::OFS_CTRL, 32'he);
    wout(7'h0f, "no mask no request");
    wr(mip_pkg::OFS_MASK, 32'h4000);
    wout(7'h1e, "stale flag seen");
    wr(mip_pkg::OFS_MASK, 32'h7ffd);
    wout(7'h10, "pin on top");
    peer.lvl(1'b1, 1'b1);
    for (int i = 0; i < 14; i++) begin
      if (i != 1) begin
        wr(mip_pkg::OFS_FLAG, 32'h1 << i);
        e = (i == 0) ? 2 : i + 1;
        wout(7'h10 | 7'(e), "rank order");
      end
    end
    $display("test priority done");
    peer.pulse(9'h1);
    wout(7'h1d, "sync over async");
    wr(mip_pkg::OFS_PROMO, 32'he);
    wout(7'h1e, "promoted async");
    wr(mip_pkg::OFS_PROMO, 32'hf);
    wout(7'h1d, "no promotion");
    wr(mip_pkg::OFS_FLAG, 32'h0);
    rdc(mip_pkg::OFS_FLAG, 32'h6000, 32'h6000, "zero write keeps");
    wr(mip_pkg::OFS_FLAG, 32'h2000);
    rdc(mip_pkg::OFS_FLAG, 32'h4000, 32'h6000, "one write clears");
    $display("test promotion done");
    peer.pulse(9'h80);
    wout(7'h2e, "service entry");
    peer.pulse(9'h100);
    wout(7'h1e, "service return");
    peer.lvl(1'b1, 1'b0);
    wout(7'h4e, "nmi wins");
    peer.lvl(1'b1, 1'b1);
    wout(7'h1e, "nmi gone");
    apb(1'b0, 8'h30, 32'h0);
    chk(rv, 32'h0, "unmapped data");
    chk({31'h0, re}, 32'h1, "unmapped error");
    wr(mip_pkg::OFS_FLAG, 32'h2);
    wr(mip_pkg::OFS_MASK, 32'h7fff);
    wout(7'h11, "fresh tick");
    $display("test service done");
    close_out();
  end
  initial begin
    #500000;
    n_errors++;
    close_out();
  end
endmodule // tb_maskable_interrupt_priority
